// file: rtl/mspi_pkg.sv
// Purpose: Constants, register layout and types for the master-only SPI mode of the serial transceiver.
// Assumes: 32-bit APB, one register per aligned word, byte address is four times the register index.
package mspi_pkg;

   localparam logic [7:0] STATUS_IDX       = 8'hc0;
   localparam logic [7:0] CONTROL_IDX      = 8'hc1;
   localparam logic [7:0] FORMAT_IDX       = 8'hc2;
   localparam logic [7:0] DIVISOR_LOW_IDX  = 8'hc4;
   localparam logic [7:0] DIVISOR_HIGH_IDX = 8'hc5;
   localparam logic [7:0] DATA_IDX         = 8'hc6;

   localparam int ADDR_W    = 12;
   localparam int DIVISOR_W = 12;
   localparam int FRAME_W   = 8;

   localparam int STAT_RX_COMPLETE = 7;
   localparam int STAT_TX_COMPLETE = 6;
   localparam int STAT_DATA_EMPTY  = 5;
   localparam int CTRL_RX_ENABLE   = 4;
   localparam int CTRL_TX_ENABLE   = 3;

   localparam logic [7:0]  FORMAT_RESET  = 8'h06;
   localparam logic [11:0] DIVISOR_RESET = 12'h000;
   localparam logic [1:0]  MODE_MASTER_SPI = 2'b11;
   localparam logic [3:0]  LAST_EDGE = 4'hf;
   localparam logic [1:0]  RX_DEPTH  = 2'h2;

   typedef struct packed {
      logic [1:0] operating_mode_sel;
      logic [2:0] spare;
      logic       bit_order_sel;
      logic       clock_phase_sel;
      logic       clock_polarity_sel;
   } format_type;

   typedef enum logic {IDLE, SHIFT} state_type;

   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'b00, idx, 2'b00};
   endfunction

endpackage

// file: rtl/baud_divider.sv
// Purpose: Baud prescaler giving one enable pulse per serial clock half period.
// Assumes: Half period is divisor plus one system clocks.
// Notes:   Reload restarts the count from zero.
`timescale 1ns/1ps
module baud_divider
   import mspi_pkg::*;
(
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 reload_i,
   input  wire logic [DIVISOR_W-1:0] divisor_i,
   output logic                      tick_o
);
   logic [DIVISOR_W-1:0] count;
   logic [DIVISOR_W-1:0] next_count;
   logic                 next_tick;

   always_comb begin
      next_count = count + 12'h001;
      next_tick  = 1'b0;
      if (reload_i) begin
         next_count = '0;
      end else if (count == divisor_i) begin
         next_count = '0;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else begin
         count  <= next_count;
         tick_o <= next_tick;
      end
   end
endmodule

// file: rtl/usart_master_spi_mode.sv
// Purpose: Master-only SPI engine of the serial transceiver with APB register access.
// Assumes: Serial input is synchronous to sys_clk_i; the slave answers within the half period.
// Notes:   One transmit buffer byte plus shifter, two-entry receive buffer; APB answers in one wait state.
`timescale 1ns/1ps
module usart_master_spi_mode
   import mspi_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic       [31:0]      prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              serial_in_pin_i,
   output logic                   serial_clock_pin_o,
   output logic                   serial_out_pin_o,
   output logic                   serial_out_en_o
);
   state_type            state;
   state_type            next_state;
   format_type           fmt;
   format_type           next_fmt;
   logic [DIVISOR_W-1:0] divisor;
   logic [DIVISOR_W-1:0] next_divisor;
   logic                 receiver_enable;
   logic                 next_receiver_enable;
   logic                 transmitter_enable;
   logic                 next_transmitter_enable;
   logic [3:0]           edge_cnt;
   logic [3:0]           next_edge_cnt;
   logic [7:0]           tx_shift;
   logic [7:0]           next_tx_shift;
   logic [7:0]           rx_shift;
   logic [7:0]           next_rx_shift;
   logic [7:0]           tx_buf;
   logic [7:0]           next_tx_buf;
   logic                 tx_full;
   logic                 next_tx_full;
   logic                 tx_complete_flag;
   logic                 next_tx_complete_flag;
   logic [7:0]           rx_mem [2];
   logic [7:0]           next_rx_mem [2];
   logic                 rx_head;
   logic                 next_rx_head;
   logic [1:0]           rx_count;
   logic [1:0]           next_rx_count;
   logic                 sck;
   logic                 next_sck;
   logic                 mosi;
   logic                 next_mosi;
   logic [31:0]          next_prdata;
   logic                 next_pready;
   logic                 next_pslverr;
   logic                 tick;
   logic                 reload;
   logic                 done;
   logic                 wr;
   logic                 rd;
   logic                 spi_on;
   logic                 sample_now;
   logic                 setup_now;

   function automatic logic pick_bit(input logic [7:0] v, input logic lsb_first);
      pick_bit = lsb_first ? v[0] : v[FRAME_W-1];
   endfunction

   function automatic logic [7:0] shift_out(input logic [7:0] v, input logic lsb_first);
      shift_out = lsb_first ? {1'b1, v[7:1]} : {v[6:0], 1'b1};
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == reg_addr(idx));
   endfunction

   // The write or read takes effect only at the edge where pready is sampled high.
   assign done = psel_i & penable_i & pready_o;
   assign wr   = done & pwrite_i;
   assign rd   = done & ~pwrite_i;

   assign spi_on = (fmt.operating_mode_sel == MODE_MASTER_SPI) & transmitter_enable;

   // prescaler reload
   // Holding reload while idle makes the first half period of a frame a full one.
   assign reload = (wr & hit(paddr_i, DIVISOR_LOW_IDX)) | (state == IDLE);

   baud_divider u_baud (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .reload_i  (reload),
      .divisor_i (divisor),
      .tick_o    (tick)
   );

   always_comb begin
      sample_now = (edge_cnt[0] == fmt.clock_phase_sel);
      setup_now  = ~sample_now & (edge_cnt != LAST_EDGE);
   end

   always_comb begin
      next_pready  = psel_i & penable_i & ~pready_o;
      next_prdata  = prdata_o;
      next_pslverr = 1'b0;
      if (next_pready) begin
         next_prdata = '0;
         if (!pwrite_i) begin
            if (hit(paddr_i, STATUS_IDX)) begin
               next_prdata[STAT_RX_COMPLETE] = (rx_count != 2'h0);
               next_prdata[STAT_TX_COMPLETE] = tx_complete_flag;
               next_prdata[STAT_DATA_EMPTY]  = ~tx_full;
            end
            if (hit(paddr_i, CONTROL_IDX)) begin
               next_prdata[CTRL_RX_ENABLE] = receiver_enable;
               next_prdata[CTRL_TX_ENABLE] = transmitter_enable;
            end
            if (hit(paddr_i, FORMAT_IDX)) begin
               next_prdata[7:0] = fmt;
            end
            if (hit(paddr_i, DIVISOR_LOW_IDX)) begin
               next_prdata[7:0] = divisor[7:0];
            end
            if (hit(paddr_i, DIVISOR_HIGH_IDX)) begin
               next_prdata[3:0] = divisor[11:8];
            end
            if (hit(paddr_i, DATA_IDX)) begin
               next_prdata[7:0] = rx_mem[rx_head];
            end
         end
         next_pslverr = ~(hit(paddr_i, STATUS_IDX) | hit(paddr_i, CONTROL_IDX) | hit(paddr_i, FORMAT_IDX)
                        | hit(paddr_i, DIVISOR_LOW_IDX) | hit(paddr_i, DIVISOR_HIGH_IDX)
                        | hit(paddr_i, DATA_IDX));
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         prdata_o  <= next_prdata;
         pready_o  <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end

   always_comb begin
      logic [7:0] sh;
      logic [7:0] rx;
      logic [1:0] cnt;
      logic       hd;
      sh  = tx_shift;
      rx  = rx_shift;
      cnt = rx_count;
      hd  = rx_head;
      next_state              = state;
      next_fmt                = fmt;
      next_divisor            = divisor;
      next_receiver_enable    = receiver_enable;
      next_transmitter_enable = transmitter_enable;
      next_edge_cnt           = edge_cnt;
      next_tx_buf             = tx_buf;
      next_tx_full            = tx_full;
      next_tx_complete_flag   = tx_complete_flag;
      next_rx_mem             = rx_mem;
      next_sck                = sck;
      next_mosi               = mosi;

      if (wr) begin
         if (hit(paddr_i, STATUS_IDX) && pwdata_i[STAT_TX_COMPLETE]) begin
            next_tx_complete_flag = 1'b0;
         end
         if (hit(paddr_i, CONTROL_IDX)) begin
            next_receiver_enable    = pwdata_i[CTRL_RX_ENABLE];
            next_transmitter_enable = pwdata_i[CTRL_TX_ENABLE];
            // Turning the receiver off flushes whatever it had buffered.
            if (!pwdata_i[CTRL_RX_ENABLE]) begin
               cnt = 2'h0;
            end
         end
         if (hit(paddr_i, FORMAT_IDX)) begin
            next_fmt = format_type'(pwdata_i[7:0]);
         end
         if (hit(paddr_i, DIVISOR_LOW_IDX)) begin
            next_divisor[7:0] = pwdata_i[7:0];
         end
         if (hit(paddr_i, DIVISOR_HIGH_IDX)) begin
            next_divisor[11:8] = pwdata_i[3:0];
         end
         if (hit(paddr_i, DATA_IDX) && spi_on && !tx_full) begin
            next_tx_buf  = pwdata_i[7:0];
            next_tx_full = 1'b1;
         end
      end
      if (rd && hit(paddr_i, DATA_IDX) && cnt != 2'h0) begin
         hd  = ~hd;
         cnt = cnt - 2'h1;
      end

      case (state)
         IDLE: begin
            next_sck = fmt.clock_polarity_sel;
            // data idles high
            // Raising the line here, not on the last edge, keeps it stable across a phase 1 sample edge.
            next_mosi = 1'b1;
            if (tx_full && spi_on) begin
               sh            = tx_buf;
               next_tx_full  = 1'b0;
               next_edge_cnt = 4'h0;
               next_state    = SHIFT;
               if (!fmt.clock_phase_sel) begin
                  next_mosi = pick_bit(sh, fmt.bit_order_sel);
                  sh        = shift_out(sh, fmt.bit_order_sel);
               end
            end
         end
         SHIFT: begin
            if (tick) begin
               next_sck      = ~sck;
               next_edge_cnt = edge_cnt + 4'h1;
               if (sample_now) begin
                  rx = fmt.bit_order_sel ? {serial_in_pin_i, rx[7:1]} : {rx[6:0], serial_in_pin_i};
               end
               if (setup_now) begin
                  next_mosi = pick_bit(sh, fmt.bit_order_sel);
                  sh        = shift_out(sh, fmt.bit_order_sel);
               end
               if (edge_cnt == LAST_EDGE) begin
                  if (receiver_enable && cnt != RX_DEPTH) begin
                     next_rx_mem[hd ^ cnt[0]] = rx;
                     cnt                     = cnt + 2'h1;
                  end
                  if (tx_full && spi_on) begin
                     sh            = tx_buf;
                     next_tx_full  = 1'b0;
                     next_edge_cnt = 4'h0;
                     if (!fmt.clock_phase_sel) begin
                        next_mosi = pick_bit(sh, fmt.bit_order_sel);
                        sh        = shift_out(sh, fmt.bit_order_sel);
                     end
                  end else begin
                     next_state            = IDLE;
                     next_tx_complete_flag = 1'b1;
                  end
               end
            end
         end
         default: begin
            next_state = IDLE;
         end
      endcase
      next_tx_shift = sh;
      next_rx_shift = rx;
      next_rx_count = cnt;
      next_rx_head  = hd;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state              <= IDLE;
         fmt                <= format_type'(FORMAT_RESET);
         divisor            <= DIVISOR_RESET;
         receiver_enable    <= 1'b0;
         transmitter_enable <= 1'b0;
         edge_cnt           <= 4'h0;
         tx_shift           <= 8'hff;
         rx_shift           <= 8'h00;
         tx_buf             <= 8'h00;
         tx_full            <= 1'b0;
         tx_complete_flag   <= 1'b0;
         rx_mem[0]          <= 8'h00;
         rx_mem[1]          <= 8'h00;
         rx_head            <= 1'b0;
         rx_count           <= 2'h0;
         sck                <= 1'b0;
         mosi               <= 1'b1;
      end else begin
         state              <= next_state;
         fmt                <= next_fmt;
         divisor            <= next_divisor;
         receiver_enable    <= next_receiver_enable;
         transmitter_enable <= next_transmitter_enable;
         edge_cnt           <= next_edge_cnt;
         tx_shift           <= next_tx_shift;
         rx_shift           <= next_rx_shift;
         tx_buf             <= next_tx_buf;
         tx_full            <= next_tx_full;
         tx_complete_flag   <= next_tx_complete_flag;
         rx_mem             <= next_rx_mem;
         rx_head            <= next_rx_head;
         rx_count           <= next_rx_count;
         sck                <= next_sck;
         mosi               <= next_mosi;
      end
   end

   // Clock and data pins are plain copies of the state flops and the enable pin is registered too, so they stay glitch free.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serial_clock_pin_o <= 1'b0;
         serial_out_pin_o   <= 1'b1;
         serial_out_en_o    <= 1'b0;
      end else begin
         serial_clock_pin_o <= next_sck;
         serial_out_pin_o   <= next_mosi;
         serial_out_en_o    <= next_transmitter_enable | (next_state == SHIFT);
      end
   end
endmodule

// file: verif/mspi_monitor.sv
// Purpose: Checker for the master SPI engine, bound to its top module.
// Assumes: Format, enable and divisor are tracked from completed APB writes.
// Notes:   A polarity change at rest is not counted as a frame edge.
`timescale 1ns/1ps
module mspi_monitor
   import mspi_pkg::*;
(
   input wire logic              sys_clk_i,
   input wire logic              rst_n_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0]       pwdata_i,
   input wire logic [31:0]       prdata_o,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   input wire logic              serial_in_pin_i,
   input wire logic              serial_clock_pin_o,
   input wire logic              serial_out_pin_o,
   input wire logic              serial_out_en_o
);
   format_type  fmt, next_fmt;
   logic [11:0] div, next_div;
   logic [3:0]  tog, next_tog;
   logic [12:0] gap, next_gap;
   logic        tx_en, next_tx_en, sck_d, cpol_d, wr, rd, tg;
   assign wr = psel_i & penable_i & pready_o & pwrite_i;
   assign rd = psel_i & penable_i & pready_o & ~pwrite_i;
   assign tg = (serial_clock_pin_o != sck_d) & (tog != 4'h0 | serial_clock_pin_o != fmt.clock_polarity_sel);
   always_comb begin
      next_fmt = fmt;
      next_div = div;
      next_tx_en = tx_en;
      if (wr && paddr_i == reg_addr(FORMAT_IDX)) next_fmt = format_type'(pwdata_i[7:0]);
      if (wr && paddr_i == reg_addr(DIVISOR_LOW_IDX)) next_div[7:0] = pwdata_i[7:0];
      if (wr && paddr_i == reg_addr(DIVISOR_HIGH_IDX)) next_div[11:8] = pwdata_i[3:0];
      if (wr && paddr_i == reg_addr(CONTROL_IDX)) next_tx_en = pwdata_i[CTRL_TX_ENABLE];
      next_tog = tg ? tog + 4'h1 : tog;
      next_gap = (serial_clock_pin_o != sck_d) ? 13'h0001 : gap + {12'h000, gap != 13'h1fff};
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fmt <= format_type'(FORMAT_RESET);
         div <= DIVISOR_RESET;
         tx_en <= 1'b0;
         tog <= 4'h0;
         gap <= 13'h0000;
         sck_d <= 1'b0;
         cpol_d <= 1'b0;
      end else begin
         fmt <= next_fmt;
         div <= next_div;
         tx_en <= next_tx_en;
         tog <= next_tog;
         gap <= next_gap;
         sck_d <= serial_clock_pin_o;
         cpol_d <= fmt.clock_polarity_sel;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_mosi_setup;
      $changed(serial_out_pin_o) && tog != 4'h0 |->
         tg && (tog == 4'hf || serial_clock_pin_o == (fmt.clock_polarity_sel ^ fmt.clock_phase_sel));
   endproperty
   a_mosi_setup: assert property (p_mosi_setup) else $error("data changed off a setup edge");
   property p_idle_clk;
      tog == 4'h0 && !tg && fmt.clock_polarity_sel == cpol_d |-> serial_clock_pin_o == cpol_d;
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("serial clock left its rest level");
   property p_half;
      tg && tog != 4'h0 |-> gap == {1'b0, div} + 13'h0001;
   endproperty
   a_half: assert property (p_half) else $error("half period differs from divisor plus one");
   property p_mode;
      tg |-> fmt.operating_mode_sel == MODE_MASTER_SPI;
   endproperty
   a_mode: assert property (p_mode) else $error("shifting outside master SPI mode");
   property p_start;
      tg && tog == 4'h0 |-> tx_en;
   endproperty
   a_start: assert property (p_start) else $error("frame started with transmitter off");
   property p_out_en;
      tg |-> serial_out_en_o;
   endproperty
   a_out_en: assert property (p_out_en) else $error("data pin not driven while shifting");
   property p_err_flags;
      rd && paddr_i == reg_addr(STATUS_IDX) |-> prdata_o[4:2] == 3'b000;
   endproperty
   a_err_flags: assert property (p_err_flags) else $error("receive error flags not zero");
   property p_div_low;
      rd && paddr_i == reg_addr(DIVISOR_LOW_IDX) |-> prdata_o == {24'h000000, div[7:0]};
   endproperty
   a_div_low: assert property (p_div_low) else $error("low divisor readback wrong");
   property p_div_high;
      rd && paddr_i == reg_addr(DIVISOR_HIGH_IDX) |-> prdata_o == {28'h0000000, div[11:8]};
   endproperty
   a_div_high: assert property (p_div_high) else $error("high divisor readback wrong");
   c_frame_end: cover property (tg && tog == 4'hf);
   c_slverr: cover property (pslverr_o && pready_o);
   c_status: cover property (rd && paddr_i == reg_addr(STATUS_IDX));
endmodule
bind usart_master_spi_mode mspi_monitor i_monitor (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_in_pin_i(serial_in_pin_i),
   .serial_clock_pin_o(serial_clock_pin_o), .serial_out_pin_o(serial_out_pin_o), .serial_out_en_o(serial_out_en_o));

// file: verif/spi_slave_model.sv
// Purpose: SPI slave that answers each frame with the inverse of the byte it last received.
// Assumes: Mode and order inputs match the master's format while a frame runs.
// Notes:   Reacts on serial clock edges directly, so it keeps up at any divisor.
`timescale 1ns/1ps
module spi_slave_model (
   input  wire logic  sck_i,
   input  wire logic  mosi_i,
   input  wire logic  cpol_i,
   input  wire logic  cpha_i,
   input  wire logic  lsb_i,
   output logic       miso_o,
   output logic [7:0] got_o,
   output int         frames_o
);
   logic [7:0] sh = 8'h00;
   int         cnt = 0;
   logic       lead = 1'b0;
   initial begin
      got_o = 8'h00;
      frames_o = 0;
      miso_o = 1'b1;
   end
   always @(sck_i) begin
      if (cpha_i && sck_i == cpol_i && !lead) begin
         // A return to rest with no leading edge before it is only a polarity change at rest.
      end else if ((sck_i != cpol_i) == !cpha_i) begin
         lead = 1'b0;
         sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
         cnt = cnt + 1;
         if (cnt == 8) begin
            cnt = 0;
            got_o = sh;
            frames_o = frames_o + 1;
         end
      end else begin
         // In phase 1 the leading edge sets up, so the trailing edge after it is a real sample.
         lead = cpha_i;
         miso_o = lsb_i ? ~got_o[cnt] : ~got_o[7-cnt];
      end
   end
endmodule

// file: verif/testbench.sv
// Purpose: Self-checking bench for the master SPI engine.
// Assumes: The slave model answers with the inverse of the previous byte.
// Notes:   Random bytes and divisors come from a fixed xorshift seed.
`timescale 1ns/1ps
module testbench
   import mspi_pkg::*;
;
   logic        sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd13758;
   logic        pready, pslverr, sck, mosi, oen, miso, err;
   logic [7:0]  fmt = FORMAT_RESET, tx, prev, got;
   int          error_cnt = 0, compares = 0, cyc = 0, f0, frames;
   usart_master_spi_mode i_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .serial_in_pin_i(miso), .serial_clock_pin_o(sck), .serial_out_pin_o(mosi),
      .serial_out_en_o(oen));
   spi_slave_model i_slave (.sck_i(sck), .mosi_i(mosi), .cpol_i(fmt[0]), .cpha_i(fmt[1]), .lsb_i(fmt[2]),
      .miso_o(miso), .got_o(got), .frames_o(frames));
   initial forever #2.5 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] reply(input logic [7:0] last);
      return {24'h000000, ~last};
   endfunction
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer.
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_tx();
      int n;
      n = 0;
      do begin
         apb(1'b0, STATUS_IDX, 32'h0);
         n++;
      end while (rd[STAT_TX_COMPLETE] !== 1'b1 && n < 300);
      chk("tx complete", 32'h1, {31'h0, rd[STAT_TX_COMPLETE]});
      chk("error flags", 32'h0, {29'h0, rd[4:2]});
      apb(1'b1, STATUS_IDX, 32'h40);
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b0, DIVISOR_LOW_IDX, 32'h0);
      chk("div low", 32'h0, rd);
      apb(1'b0, FORMAT_IDX, 32'h0);
      chk("format", {24'h0, FORMAT_RESET}, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, DIVISOR_HIGH_IDX, 32'hff);
      apb(1'b0, DIVISOR_HIGH_IDX, 32'h0);
      chk("div high", 32'h0f, rd);
      apb(1'b1, DIVISOR_HIGH_IDX, 32'h0);
      apb(1'b1, CONTROL_IDX, 32'h18);
      $display("test registers done");
      prev = 8'h00;
      for (int m = 0; m < 8; m++) begin
         fmt = {MODE_MASTER_SPI, 3'b000, 3'(m)};
         apb(1'b1, FORMAT_IDX, {24'h0, fmt});
         apb(1'b1, DIVISOR_LOW_IDX, rnd() & 32'h3);
         tx = 8'(rnd());
         apb(1'b1, DATA_IDX, {24'h0, tx});
         wait_tx();
         chk("slave byte", {24'h0, tx}, {24'h0, got});
         apb(1'b0, DATA_IDX, 32'h0);
         chk("rx byte", reply(prev), rd);
         chk("clock rest", {31'h0, fmt[0]}, {31'h0, sck});
         chk("data rest", 32'h1, {31'h0, mosi});
         chk("out enable", 32'h1, {31'h0, oen});
         prev = tx;
      end
      $display("test modes done");
      fmt = {MODE_MASTER_SPI, 6'h00};
      apb(1'b1, FORMAT_IDX, {24'h0, fmt});
      apb(1'b1, DIVISOR_LOW_IDX, 32'h1);
      f0 = frames;
      tx = 8'(rnd());
      apb(1'b1, DATA_IDX, {24'h0, tx});
      apb(1'b1, DATA_IDX, {24'h0, ~tx});
      wait_tx();
      chk("frames", 32'(f0 + 2), 32'(frames));
      apb(1'b1, DATA_IDX, 32'h3c);
      wait_tx();
      apb(1'b0, DATA_IDX, 32'h0);
      chk("rx first", reply(prev), rd);
      apb(1'b0, DATA_IDX, 32'h0);
      chk("rx second", reply(tx), rd);
      apb(1'b0, STATUS_IDX, 32'h0);
      chk("rx empty", 32'h0, {31'h0, rd[STAT_RX_COMPLETE]});
      $display("test queue done");
      apb(1'b1, CONTROL_IDX, 32'h08);
      f0 = frames;
      apb(1'b1, DATA_IDX, 32'h5a);
      wait_tx();
      chk("tx alone", 32'(f0 + 1), 32'(frames));
      apb(1'b0, STATUS_IDX, 32'h0);
      chk("rx off", 32'h0, {31'h0, rd[STAT_RX_COMPLETE]});
      fmt = 8'h00;
      apb(1'b1, FORMAT_IDX, 32'h0);
      apb(1'b1, DATA_IDX, 32'ha5);
      repeat (100) @(posedge sys_clk);
      chk("no shift", 32'(f0 + 1), 32'(frames));
      $display("test gating done");
      end_sim();
   end
endmodule
